// ==== logic/lcc_cell.v ====
// one logic cell: lookup table, adder, carry and configurable flop
`timescale 1ns/1ps
`default_nettype none
`include "lcc_regs.vh"

module lcc_cell (
	input  wire        clk_i,       // system clock
	input  wire        rst_i,       // sync reset, high
	input  wire [31:0] cfg_i,       // cell configuration word
	input  wire [3:0]  data_i,      // four data inputs
	input  wire        carry_i,     // carry from preceding cell
	input  wire        chain_i,     // register chain in
	input  wire        tick_one_i,  // gated cluster clock one event
	input  wire        tick_two_i,  // gated cluster clock two event
	input  wire        aclr_one_i,  // cluster async clear one
	input  wire        aclr_two_i,  // cluster async clear two
	input  wire        sclr_i,      // cluster sync clear
	input  wire        sload_i,     // cluster sync load
	input  wire        devclr_i,    // chip-wide clear, qualified
	output wire        lut_o,       // unregistered table result
	output wire        reg_o,       // visible register value
	output wire        carry_o      // carry to next cell
);

////////////////////////////////////////////////////////////////////////////////
wire [15:0] mask    = cfg_i[`LCC_CF_MASK_HI:`LCC_CF_MASK_LO];
wire        arith   = cfg_i[`LCC_CF_ARITH];
wire        pack    = cfg_i[`LCC_CF_PACK];
wire        preset  = cfg_i[`LCC_CF_PRESET];
wire [1:0]  ff_type = cfg_i[`LCC_CF_TYPE_HI:`LCC_CF_TYPE_LO];
wire [1:0]  clr_sel = cfg_i[`LCC_CF_CLR_HI:`LCC_CF_CLR_LO];

reg  q;
wire q_vis = q ^ preset;
wire d0 = cfg_i[`LCC_CF_FB] ? q_vis : data_i[0];
wire d3 = cfg_i[`LCC_CF_USE_CIN] ? carry_i : data_i[3];

// arithmetic: low half gives sum, high half gives carry out
assign lut_o   = arith ? mask[{1'b0, carry_i, data_i[1], d0}]
                       : mask[{d3, data_i[2], data_i[1], d0}];
assign carry_o = arith ? mask[{1'b1, carry_i, data_i[1], d0}]
                       : carry_i;
assign reg_o   = q_vis;

////////////////////////////////////////////////////////////////////////////////
// packed flop takes data four directly, table stays free
wire din = pack ? data_i[3]
               : (cfg_i[`LCC_CF_CHAIN] ? chain_i : lut_o);
wire dp  = din ^ preset;
wire tick = cfg_i[`LCC_CF_CLKSEL] ? tick_two_i : tick_one_i;
wire aclr = (clr_sel == `LCC_CLR_ONE) ? aclr_one_i :
            (clr_sel == `LCC_CLR_TWO) ? aclr_two_i : 1'b0;

reg next_q;
always @* begin
	case (ff_type)
	`LCC_FF_D:  next_q = dp;
	`LCC_FF_T:  next_q = q ^ din;
	`LCC_FF_JK: next_q = (dp & ~q) | (~data_i[2] & q);
	`LCC_FF_SR: next_q = dp | (q & ~data_i[2]);
	default:    next_q = dp;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i || devclr_i) begin
		q <= 1'b0;
	end else if (aclr) begin
		q <= 1'b0;
	end else if (tick) begin
		if (sclr_i) begin
			q <= 1'b0;
		end else if (sload_i && !pack) begin
			q <= data_i[2] ^ preset;
		end else begin
			q <= next_q;
		end
	end
end

endmodule // lcc_cell
`default_nettype wire

// ==== logic/lcc_cluster.v ====
// logic cluster of sixteen cells with control logic and register bus
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_regs.vh"

module lcc_cluster #(
	parameter CELLS = 16,
	parameter ROWS  = 6,
	parameter LOCS  = 4
) (
	input  wire                 clk_i,               // 40 MHz clock
	input  wire                 rst_i,               // sync reset, high
	input  wire                 wb_cyc_i,            // bus cycle
	input  wire                 wb_stb_i,            // bus strobe
	input  wire                 wb_we_i,             // bus write
	input  wire [7:0]           wb_adr_i,            // byte address
	input  wire [3:0]           wb_sel_i,            // byte lanes
	input  wire [31:0]          wb_dat_i,            // write data
	output reg  [31:0]          wb_dat_o,            // read data
	output reg                  wb_ack_o,            // bus acknowledge
	input  wire [ROWS-1:0]      row_clock_i,         // row clock lines
	input  wire [LOCS-1:0]      ctrl_local_i,        // local control lines
	input  wire [4*CELLS-1:0]   data_i,              // cell data inputs
	input  wire                 carry_i,             // carry from cluster above
	input  wire                 chain_i,             // register chain in
	input  wire                 chip_wide_clear_n_i, // chip clear, low
	output reg  [CELLS-1:0]     lut_o,               // table outputs
	output reg  [CELLS-1:0]     reg_o,               // register outputs
	output reg                  carry_o,             // carry to next cluster
	output reg                  chain_o              // register chain out
);

////////////////////////////////////////////////////////////////////////////////
// configuration storage
reg [31:0] cell_cfg [0:CELLS-1];
reg [31:0] ctrl;
reg [3:0]  opt;
reg        refused;

// control source: row line, local line or unused
function src_bit;
	input [3:0]      sel;
	input [ROWS-1:0] row;
	input [LOCS-1:0] loc;
	begin
		src_bit = 1'b0;
		if (sel < `LCC_SRC_ROWS)
			src_bit = row[sel[2:0]];
		else if (sel[3:2] == `LCC_SRC_LOCAL)
			src_bit = loc[sel[1:0]];
	end
endfunction

// how many of the eight controls draw on local routing
function [3:0] local_count;
	input [31:0] c;
	integer i;
	begin
		local_count = 4'h0;
		for (i = 0; i < 8; i = i + 1) begin
			if (c[4*i+3 -: 2] == `LCC_SRC_LOCAL)
				local_count = local_count + 4'h1;
		end
	end
endfunction

function [31:0] merge;
	input [31:0] old;
	input [31:0] new_v;
	input [3:0]  sel;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (sel[i])
				merge[8*i +: 8] = new_v[8*i +: 8];
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// row clock and chip clear synchronisers
reg [ROWS-1:0] row_s1;
reg [ROWS-1:0] row_s2;
reg [ROWS-1:0] row_s3;
reg [LOCS-1:0] loc_prev;
reg            clr_s1;
reg            clr_s2;

always @(posedge clk_i) begin
	if (rst_i) begin
		row_s1   <= {ROWS{1'b0}};
		row_s2   <= {ROWS{1'b0}};
		row_s3   <= {ROWS{1'b0}};
		loc_prev <= {LOCS{1'b0}};
		clr_s1   <= 1'b1;
		clr_s2   <= 1'b1;
	end else begin
		row_s1   <= row_clock_i;
		row_s2   <= row_s1;
		row_s3   <= row_s2;
		loc_prev <= ctrl_local_i;
		clr_s1   <= chip_wide_clear_n_i;
		clr_s2   <= clr_s1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// cluster-wide control generation
wire [3:0] sel_clk1  = ctrl[3:0];
wire [3:0] sel_clk2  = opt[`LCC_OPT_PAIR] ? ctrl[3:0] : ctrl[7:4];
wire [3:0] sel_ena1  = ctrl[11:8];
wire [3:0] sel_ena2  = ctrl[15:12];
wire [3:0] sel_clr1  = ctrl[19:16];
wire [3:0] sel_clr2  = ctrl[23:20];
wire [3:0] sel_sclr  = ctrl[27:24];
wire [3:0] sel_sload = ctrl[31:28];

wire fall1 = opt[`LCC_OPT_FALL_ONE];
wire fall2 = opt[`LCC_OPT_PAIR] ? ~fall1 : opt[`LCC_OPT_FALL_TWO];

wire cur1 = src_bit(sel_clk1, row_s2, ctrl_local_i);
wire prv1 = src_bit(sel_clk1, row_s3, loc_prev);
wire cur2 = src_bit(sel_clk2, row_s2, ctrl_local_i);
wire prv2 = src_bit(sel_clk2, row_s3, loc_prev);
wire edge1 = fall1 ? (prv1 & ~cur1) : (cur1 & ~prv1);
wire edge2 = fall2 ? (prv2 & ~cur2) : (cur2 & ~prv2);

// unused enable means always enabled
wire ena1 = (sel_ena1 == `LCC_SRC_NONE) ? 1'b1 :
            src_bit(sel_ena1, row_s2, ctrl_local_i);
wire ena2 = (sel_ena2 == `LCC_SRC_NONE) ? 1'b1 :
            src_bit(sel_ena2, row_s2, ctrl_local_i);

wire tick1 = edge1 & ena1;
wire tick2 = edge2 & ena2;
wire aclr1 = src_bit(sel_clr1, row_s2, ctrl_local_i);
wire aclr2 = src_bit(sel_clr2, row_s2, ctrl_local_i);
wire sclr  = src_bit(sel_sclr, row_s2, ctrl_local_i);
wire sload = src_bit(sel_sload, row_s2, ctrl_local_i) & ~sclr;
wire devclr = opt[`LCC_OPT_CHIPCLR] & ~clr_s2;

////////////////////////////////////////////////////////////////////////////////
// sixteen cells with carry and register chains
wire [CELLS:0]   carry_v;
wire [CELLS:0]   chain_v;
wire [CELLS-1:0] lut_w;
wire [CELLS-1:0] reg_w;

assign carry_v[0] = carry_i;
assign chain_v[0] = chain_i;

genvar k;
generate
	for (k = 0; k < CELLS; k = k + 1) begin : g_cell
		lcc_cell u_cell (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.cfg_i      (cell_cfg[k]),
			.data_i     (data_i[4*k +: 4]),
			.carry_i    (carry_v[k]),
			.chain_i    (chain_v[k]),
			.tick_one_i (tick1),
			.tick_two_i (tick2),
			.aclr_one_i (aclr1),
			.aclr_two_i (aclr2),
			.sclr_i     (sclr),
			.sload_i    (sload),
			.devclr_i   (devclr),
			.lut_o      (lut_w[k]),
			.reg_o      (reg_w[k]),
			.carry_o    (carry_v[k+1])
		);
		assign chain_v[k+1] = reg_w[k];
	end
endgenerate

// outputs face local routing and the left and right neighbours
always @(posedge clk_i) begin
	if (rst_i) begin
		lut_o   <= {CELLS{1'b0}};
		reg_o   <= {CELLS{1'b0}};
		carry_o <= 1'b0;
		chain_o <= 1'b0;
	end else begin
		lut_o   <= lut_w;
		reg_o   <= reg_w;
		carry_o <= carry_v[CELLS];
		chain_o <= reg_w[CELLS-1];
	end
end

////////////////////////////////////////////////////////////////////////////////
// register bus slave, one wait state
wire       bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire       bus_wr   = bus_req & wb_we_i;
wire       in_cells = (wb_adr_i < `LCC_CTRL);
wire [3:0] cell_idx = wb_adr_i[5:2];
wire [31:0] ctrl_new = merge(ctrl, wb_dat_i, wb_sel_i);
wire        ctrl_ok  = (local_count(ctrl_new) <= `LCC_MAX_LOCAL);
wire [3:0]  loc_used = local_count(ctrl);

integer n;
always @(posedge clk_i) begin
	if (rst_i) begin
		for (n = 0; n < CELLS; n = n + 1)
			cell_cfg[n] <= `LCC_CELL_RST;
		ctrl    <= `LCC_CTRL_RST;
		opt     <= `LCC_OPT_RST;
		refused <= 1'b0;
	end else if (bus_wr) begin
		if (in_cells) begin
			cell_cfg[cell_idx] <= merge(cell_cfg[cell_idx],
			                            wb_dat_i, wb_sel_i);
		end else if (wb_adr_i == `LCC_CTRL) begin
			if (ctrl_ok)
				ctrl <= ctrl_new;
			else
				refused <= 1'b1;
		end else if (wb_adr_i == `LCC_OPT) begin
			if (wb_sel_i[0])
				opt <= wb_dat_i[3:0];
		end else if (wb_adr_i == `LCC_FLAGS) begin
			if (wb_sel_i[0] && wb_dat_i[0])
				refused <= 1'b0;
		end
	end
end

reg [31:0] next_rdata;
always @* begin
	next_rdata = 32'h0000_0000;
	if (in_cells)
		next_rdata = cell_cfg[cell_idx] & {{(32-`LCC_CF_USED){1'b0}},
		                                  {`LCC_CF_USED{1'b1}}};
	else if (wb_adr_i == `LCC_CTRL)
		next_rdata = ctrl;
	else if (wb_adr_i == `LCC_OPT)
		next_rdata = {28'h0000000, opt};
	else if (wb_adr_i == `LCC_REGSTAT)
		next_rdata = {16'h0000, reg_w};
	else if (wb_adr_i == `LCC_LUTSTAT)
		next_rdata = {16'h0000, lut_w};
	else if (wb_adr_i == `LCC_FLAGS)
		next_rdata = {24'h000000, loc_used, 2'h0, devclr, refused};
end

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= bus_req;
		wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
	end
end

endmodule // lcc_cluster
`default_nettype wire

// ==== logic/lcc_regs.vh ====
// register offsets, field positions, reset values for the logic cluster
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

// register byte offsets; cell config n sits at n*4
`define LCC_CELL_BASE    8'h00
`define LCC_CTRL         8'h40
`define LCC_OPT          8'h44
`define LCC_REGSTAT      8'h48
`define LCC_LUTSTAT      8'h4c
`define LCC_FLAGS        8'h50

// cell config fields
`define LCC_CF_MASK_LO   0
`define LCC_CF_MASK_HI   15
`define LCC_CF_ARITH     16
`define LCC_CF_USE_CIN   17
`define LCC_CF_PACK      18
`define LCC_CF_FB        19
`define LCC_CF_TYPE_LO   20
`define LCC_CF_TYPE_HI   21
`define LCC_CF_CLKSEL    22
`define LCC_CF_CLR_LO    23
`define LCC_CF_CLR_HI    24
`define LCC_CF_PRESET    25
`define LCC_CF_CHAIN     26
`define LCC_CF_USED      27

// flop types
`define LCC_FF_D         2'h0
`define LCC_FF_T         2'h1
`define LCC_FF_JK        2'h2
`define LCC_FF_SR        2'h3

// clear selects
`define LCC_CLR_NONE     2'h0
`define LCC_CLR_ONE      2'h1
`define LCC_CLR_TWO      2'h2

// control source selects: 0..5 row line, 8..b local line, f unused
`define LCC_SRC_ROWS     4'h6
`define LCC_SRC_LOCAL    2'h2
`define LCC_SRC_NONE     4'hf
`define LCC_MAX_LOCAL    4'h4

// option fields
`define LCC_OPT_FALL_ONE 0
`define LCC_OPT_FALL_TWO 1
`define LCC_OPT_PAIR     2
`define LCC_OPT_CHIPCLR  3

// reset values
`define LCC_CELL_RST     32'h0000_0000
`define LCC_CTRL_RST     32'hffff_ffff
`define LCC_OPT_RST      4'h0

`endif

// ==== test/lcc_cluster_properties.sv ====
// port assertions for the logic cluster
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster_chk #(
	parameter CELLS = 16,
	parameter ROWS  = 6,
	parameter LOCS  = 4
) (
	input wire logic               clk_i,     // clock
	input wire logic               rst_i,     // reset
	input wire logic               wb_cyc_i,  // cycle
	input wire logic               wb_stb_i,  // strobe
	input wire logic               wb_we_i,   // write
	input wire logic [7:0]         wb_adr_i,  // address
	input wire logic [3:0]         wb_sel_i,  // lanes
	input wire logic [31:0]        wb_dat_i,  // wdata
	input wire logic [31:0]        wb_dat_o,  // rdata
	input wire logic               wb_ack_o,  // ack
	input wire logic [ROWS-1:0]    row_clock_i,  // rows
	input wire logic [LOCS-1:0]    ctrl_local_i, // locals
	input wire logic [4*CELLS-1:0] data_i,    // data
	input wire logic               carry_i,   // carry in
	input wire logic               chain_i,   // chain in
	input wire logic               chip_wide_clear_n_i, // chip clear
	input wire logic [CELLS-1:0]   lut_o,     // tables
	input wire logic [CELLS-1:0]   reg_o,     // flops
	input wire logic               carry_o,   // carry out
	input wire logic               chain_o    // chain out
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] quiet;
	// cycles with no input able to move a flop or table
	always @(posedge clk_i) begin
		if (rst_i || wb_ack_o || $changed(row_clock_i)
			|| $changed(ctrl_local_i) || $changed(data_i)
			|| $changed({carry_i, chain_i, chip_wide_clear_n_i}))
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	no_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	idle_dat_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chain_out_a: assert property (chain_o == reg_o[CELLS-1])
		else $error("chain out differs from last flop");
	reset_out_a: assert property ($fell(rst_i) |->
		reg_o == '0 && lut_o == '0 && !carry_o && !chain_o)
		else $error("outputs not cleared by reset");
	quiet_reg_a: assert property (quiet == 3'h7 |->
		$stable(reg_o) && $stable(chain_o))
		else $error("flop moved without clock event");
	quiet_lut_a: assert property (quiet == 3'h7 |->
		$stable(lut_o) && $stable(carry_o))
		else $error("table moved without input change");
	cover property (wb_ack_o && wb_we_i);
	cover property ($rose(chain_o));
	cover property (quiet == 3'h7 && reg_o != '0);
endmodule // lcc_cluster_chk
`default_nettype wire

// ==== test/lcc_fabric.sv ====
// routing fabric model driving the row clock lines
`timescale 1ns/1ps
`default_nettype none
module lcc_fabric (
	input  wire logic       clk_i,       // clock
	input  wire logic       rst_i,       // sync reset
	input  wire logic [5:0] fire_i,      // lines to pulse
	output var  logic [5:0] row_clock_o  // row clock lines
);
	logic [2:0] cnt;
	// line high four cycles, low at least four more
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 3'h0;
			row_clock_o <= 6'h00;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h4)
				row_clock_o <= 6'h00;
		end else if (fire_i != 6'h00) begin
			cnt <= 3'h7;
			row_clock_o <= fire_i;
		end
	end
endmodule // lcc_fabric
`default_nettype wire

// ==== test/test_logic_cluster_cells.sv ====
// self-checking bench for the logic cluster
`timescale 1ns/1ps
`default_nettype none
module test_logic_cluster_cells;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic carry_i, chain_i, chip_wide_clear_n_i, carry_o, chain_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, ctrl_local_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [5:0]  row_clock_i, fire;
	logic [63:0] data_i;
	logic [15:0] lut_o, reg_o;
	int error_cnt, checks;
	lcc_cluster #(.CELLS(16), .ROWS(6), .LOCS(4)) dut_u (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .row_clock_i, .ctrl_local_i, .data_i,
		.carry_i, .chain_i, .chip_wide_clear_n_i, .lut_o, .reg_o,
		.carry_o, .chain_o);
	lcc_fabric fab_u (.clk_i, .rst_i, .fire_i(fire), .row_clock_o(row_clock_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	// one row line zero pulse, then settle past the tick latency
	task automatic pulse();
		@(posedge clk_i);
		fire <= 6'h01;
		@(posedge clk_i);
		fire <= 6'h00;
		repeat (12) @(posedge clk_i);
	endtask
	task automatic test_reset();
		rdchk(8'h40, 32'hffff_ffff, 32'hffff_ffff);
		rdchk(8'h44, 32'hffff_ffff, 32'h0);
		rdchk(8'h14, 32'hffff_ffff, 32'h0);
		bus(1'b1, 8'h60, 32'h1234_5678);
		rdchk(8'h60, 32'hffff_ffff, 32'h0);
		$display("reset test done");
	endtask
	task automatic test_chain();
		for (int i = 0; i < 16; i++)
			bus(1'b1, 8'(i * 4), 32'h0400_0000);
		bus(1'b1, 8'h40, 32'hffff_fff0);
		chain_i <= 1'b1;
		pulse();
		chk({16'h0, reg_o}, 32'h0001);
		chain_i <= 1'b0;
		repeat (15) pulse();
		chk({16'h0, reg_o}, 32'h8000);
		chk({31'h0, chain_o}, 32'h1);
		$display("chain test done");
	endtask
	task automatic test_sync();
		data_i <= {64{1'b1}};
		bus(1'b1, 8'h40, 32'h98ff_fff0);
		ctrl_local_i <= 4'h3;
		pulse();
		chk({16'h0, reg_o}, 32'h0000);
		ctrl_local_i <= 4'h2;
		pulse();
		chk({16'h0, reg_o}, 32'hffff);
		$display("sync control test done");
		ctrl_local_i <= 4'h0;
		bus(1'b1, 8'h40, 32'hffff_faf0);
		pulse();
		chk({16'h0, reg_o}, 32'hffff);
		ctrl_local_i <= 4'h4;
		pulse();
		chk({16'h0, reg_o}, 32'hfffe);
		$display("enable test done");
	endtask
	task automatic test_table();
		bus(1'b1, 8'h00, 32'h0000_8000);
		repeat (3) @(posedge clk_i);
		chk({31'h0, lut_o[0]}, 32'h1);
		data_i[3] <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({31'h0, lut_o[0]}, 32'h0);
		$display("table test done");
	endtask
	task automatic test_local();
		bus(1'b1, 8'h40, 32'hfff8_9ab8);
		rdchk(8'h40, 32'hffff_ffff, 32'hffff_faf0);
		rdchk(8'h50, 32'h1, 32'h1);
		bus(1'b1, 8'h40, 32'hffff_9ab8);
		rdchk(8'h40, 32'hffff_ffff, 32'hffff_9ab8);
		rdchk(8'h50, 32'h1, 32'h1);
		rdchk(8'h50, 32'hf0, 32'h40);
		bus(1'b1, 8'h50, 32'h1);
		rdchk(8'h50, 32'h1, 32'h0);
		$display("local source test done");
	endtask
	// full adder masks: low half xor3, high half majority
	task automatic test_arith();
		for (int i = 0; i < 16; i++)
			bus(1'b1, 8'(i * 4), 32'h0001_e896);
		bus(1'b1, 8'h40, 32'hffff_fff0);
		data_i <= {16{4'h1}};
		carry_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({16'h0, lut_o}, 32'h0000);
		chk({31'h0, carry_o}, 32'h1);
		carry_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({16'h0, lut_o}, 32'hffff);
		chk({31'h0, carry_o}, 32'h0);
		rdchk(8'h4c, 32'hffff, 32'hffff);
		pulse();
		chk({16'h0, reg_o}, 32'hffff);
		rdchk(8'h48, 32'hffff, 32'hffff);
		$display("arithmetic test done");
	endtask
	task automatic test_clear();
		bus(1'b1, 8'h00, 32'h0081_e896);
		bus(1'b1, 8'h40, 32'hfff8_fff0);
		ctrl_local_i <= 4'h1;
		repeat (3) @(posedge clk_i);
		chk({16'h0, reg_o}, 32'hfffe);
		ctrl_local_i <= 4'h0;
		bus(1'b1, 8'h44, 32'h8);
		chip_wide_clear_n_i <= 1'b0;
		pulse();
		chk({16'h0, reg_o}, 32'h0000);
		rdchk(8'h50, 32'h2, 32'h2);
		chip_wide_clear_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		pulse();
		chk({16'h0, reg_o}, 32'hffff);
		$display("clear test done");
	endtask
	// cell one packed: flop takes d, table keeps its own function
	task automatic test_pack();
		bus(1'b1, 8'h40, 32'h9fff_fff0);
		bus(1'b1, 8'h04, 32'h0004_ffff);
		data_i <= 64'h5555_5555_5555_5545;
		carry_i <= 1'b1;
		ctrl_local_i <= 4'h2;
		pulse();
		chk({31'h0, reg_o[0]}, 32'h1);
		chk({31'h0, reg_o[1]}, 32'h0);
		chk({31'h0, lut_o[1]}, 32'h1);
		ctrl_local_i <= 4'h0;
		carry_i <= 1'b0;
		$display("packing test done");
	endtask
	// clock two follows row zero on its falling edge
	task automatic test_pair();
		bus(1'b1, 8'h44, 32'h4);
		bus(1'b1, 8'h08, 32'h0040_0000);
		@(posedge clk_i);
		fire <= 6'h01;
		@(posedge clk_i);
		fire <= 6'h00;
		repeat (6) @(posedge clk_i);
		chk({31'h0, reg_o[2]}, 32'h1);
		repeat (8) @(posedge clk_i);
		chk({31'h0, reg_o[2]}, 32'h0);
		$display("pair test done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, carry_i, chain_i} = 5'h00;
		chip_wide_clear_n_i = 1'b1;
		{wb_adr_i, wb_dat_i, ctrl_local_i, fire, data_i} = '0;
		wb_sel_i = 4'hf;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_chain();
		test_sync();
		test_table();
		test_local();
		test_arith();
		test_clear();
		test_pack();
		test_pair();
		give_verdict();
	end
endmodule // test_logic_cluster_cells
bind lcc_cluster lcc_cluster_chk #(.CELLS(CELLS), .ROWS(ROWS), .LOCS(LOCS))
	chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .row_clock_i, .ctrl_local_i,
	.data_i, .carry_i, .chain_i, .chip_wide_clear_n_i, .lut_o, .reg_o,
	.carry_o, .chain_o);
`default_nettype wire
